// ==== ds3rx_pkg.sv ====
// Shared constants for the DS3 receive terminal port.
// Assumes a single 25 MHz system clock and frame-aligned receive bits.
`default_nettype none

package ds3rx_pkg;

  // ----------------------------------------
  // Clocking
  // ----------------------------------------
  localparam int unsigned LINE_CLOCK_KHZ = 44736;
  localparam int unsigned SYS_CLOCK_KHZ  = 25000;

  // ----------------------------------------
  // DS3 frame layout
  // ----------------------------------------
  localparam int unsigned FRAME_GROUPS   = 56;
  localparam int unsigned GROUP_BITS     = 85;
  localparam int unsigned FRAME_BITS     = FRAME_GROUPS * GROUP_BITS;
  localparam int unsigned OVERHEAD_POS   = 0;
  localparam int unsigned NIBBLES        = 1176;
  localparam int unsigned PULSE_NIBBLE   = 1175;

  // ----------------------------------------
  // Terminal interface
  // ----------------------------------------
  localparam int unsigned NIB_W          = 4;
  localparam int unsigned FIFO_DEPTH     = 8;
  localparam int unsigned NIB_HIGH_BITS  = 2;

  // ----------------------------------------
  // Counter widths
  // ----------------------------------------
  localparam int unsigned POS_W          = $clog2(GROUP_BITS);
  localparam int unsigned GRP_W          = $clog2(FRAME_GROUPS);
  localparam int unsigned NIDX_W         = $clog2(NIBBLES);

  typedef logic [POS_W-1:0]  ds3rx_pos_t;
  typedef logic [GRP_W-1:0]  ds3rx_grp_t;
  typedef logic [NIDX_W-1:0] ds3rx_nidx_t;

  localparam ds3rx_pos_t  POS_LAST   = ds3rx_pos_t'(GROUP_BITS - 1);
  localparam ds3rx_grp_t  GRP_LAST   = ds3rx_grp_t'(FRAME_GROUPS - 1);
  localparam ds3rx_nidx_t NIDX_LAST  = ds3rx_nidx_t'(NIBBLES - 1);
  localparam ds3rx_nidx_t NIDX_PULSE = ds3rx_nidx_t'(PULSE_NIBBLE - 1);

endpackage

`default_nettype wire

// ==== ds3rx_pin_sync.sv ====
// Two-stage synchroniser for pin inputs with rising-edge detect on bit 0.
// Assumes pins are asynchronous to sys_clk.
`default_nettype none
`timescale 1ns/1ps

module ds3rx_pin_sync #(
  parameter int unsigned W = 1
) (
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  // Pins
  input  wire logic [W-1:0] pinIn,
  // Synchronised view
  output logic      [W-1:0] level,
  output logic              rise
);

  logic [W-1:0] meta;
  logic [W-1:0] stable;
  logic         prevBit;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_stable;
  logic         next_prevBit;

  always_comb begin
    next_meta    = pinIn;
    next_stable  = meta;
    next_prevBit = stable[0];
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      meta    <= '0;
      stable  <= '0;
      prevBit <= 1'b0;
    end else begin
      meta    <= next_meta;
      stable  <= next_stable;
      prevBit <= next_prevBit;
    end
  end

  assign level = stable;
  assign rise  = stable[0] & ~prevBit;

endmodule

`default_nettype wire

// ==== ds3rx_fifo.sv ====
// Synchronous FIFO with valid/ready on both sides.
// Assumes DEPTH is a power of two.
`default_nettype none
`timescale 1ns/1ps

module ds3rx_fifo #(
  parameter int unsigned W     = 5,
  parameter int unsigned DEPTH = 8
) (
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  // Fill side
  input  wire logic         inValid,
  output logic              inReady,
  input  wire logic [W-1:0] inData,
  // Drain side
  output logic              outValid,
  input  wire logic         outReady,
  output logic      [W-1:0] outData
);

  localparam int unsigned AW = $clog2(DEPTH);

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wrPtr;
  logic [AW-1:0] rdPtr;
  logic [AW:0]   fill;
  logic [AW-1:0] next_wrPtr;
  logic [AW-1:0] next_rdPtr;
  logic [AW:0]   next_fill;
  logic          doPush;
  logic          doPop;

  assign inReady  = (fill != (AW+1)'(DEPTH));
  assign outValid = (fill != '0);
  assign outData  = mem[rdPtr];
  assign doPush   = inValid & inReady;
  assign doPop    = outValid & outReady;

  always_comb begin
    next_wrPtr = doPush ? wrPtr + 1'b1 : wrPtr;
    next_rdPtr = doPop ? rdPtr + 1'b1 : rdPtr;
    next_fill  = fill;
    if (doPush && !doPop) begin
      next_fill = fill + 1'b1;
    end else if (doPop && !doPush) begin
      next_fill = fill - 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wrPtr <= '0;
      rdPtr <= '0;
      fill  <= '0;
    end else begin
      wrPtr <= next_wrPtr;
      rdPtr <= next_rdPtr;
      fill  <= next_fill;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (doPush) begin
      mem[wrPtr] <= inData;
    end
  end

endmodule

`default_nettype wire

// ==== ds3rx_terminal_port.sv ====
// DS3 receive terminal port: serial and nibble payload output, plus
// regeneration of the line transmit clock and data.
// Assumes rxFrameMark comes from a frame aligner on sys_clk and is valid
// in the cycle of the receive bit strobe that carries frame bit 1.
`default_nettype none
`timescale 1ns/1ps

// Operation
// - Line transmit clock derived from transmit clock
// - Transmit data changes on transmit clock rise
// - Frame pulse low one cycle at bit 1
// - Nibble frame pulse with nibble 1175
// - Terminal clocks derived from line receive clock
// - Serial falls change data; nibble rises change
// - Exactly 1176 nibbles per frame
// - Overhead bits skipped, nibble clock stretched
// - Earliest bit on nibble bit 3
// - Nibble output only in C-bit parity
// - Serial output carries every frame bit
// - Gapped serial clock on bit 3 when enabled and serial select is set
// - Gap signal low on each overhead bit
module ds3rx_terminal_port (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_n,
  // Line receive side
  input  wire logic lineRxClock,
  input  wire logic lineRxData,
  input  wire logic rxFrameMark,
  // Mode controls
  input  wire logic cbitParityMode,
  input  wire logic serialSelect,
  input  wire logic gappedClockEnable,
  // Serial terminal output
  output logic      rxSerialClock,
  output logic      rxSerialData,
  output logic      rxFramePulseSerial,
  output logic      rxGapSignal,
  // Nibble terminal output
  output logic      rxNibbleClock,
  output logic      rxNibbleBit3,
  output logic      rxNibbleBit2,
  output logic      rxNibbleBit1,
  output logic      rxNibbleBit0,
  output logic      rxFramePulseNibble,
  output logic      rxNibbleOverrun,
  // Line transmit side
  input  wire logic transmitClockIn,
  input  wire logic txLineBit,
  output logic      txBitTake,
  output logic      lineTxClock,
  output logic      lineTxData
);

  import ds3rx_pkg::*;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic isOverhead(input ds3rx_pos_t pos);
    return pos == ds3rx_pos_t'(OVERHEAD_POS);
  endfunction

  function automatic ds3rx_pos_t wrapPos(input ds3rx_pos_t pos);
    return (pos == POS_LAST) ? '0 : pos + 1'b1;
  endfunction

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [1:0] rxPins;
  logic       rxBitEn;
  logic       txEn;

  ds3rx_pin_sync #(
    .W (2)
  ) u_rx_sync (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .pinIn   ({lineRxData, lineRxClock}),
    .level   (rxPins),
    .rise    (rxBitEn)
  );

  ds3rx_pin_sync #(
    .W (1)
  ) u_tx_sync (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .pinIn   (transmitClockIn),
    .level   (),
    .rise    (txEn)
  );

  logic rxBit;
  assign rxBit = rxPins[1];

  // ----------------------------------------
  // Frame position
  // ----------------------------------------
  ds3rx_pos_t posBit;
  ds3rx_grp_t posGroup;
  ds3rx_pos_t curBit;
  ds3rx_grp_t curGroup;
  ds3rx_pos_t next_posBit;
  ds3rx_grp_t next_posGroup;
  logic       curOvh;
  logic       curFirst;

  always_comb begin
    curBit        = rxFrameMark ? '0 : posBit;
    curGroup      = rxFrameMark ? '0 : posGroup;
    curOvh        = isOverhead(curBit);
    curFirst      = isOverhead(curBit) && (curGroup == '0);
    next_posBit   = posBit;
    next_posGroup = posGroup;
    if (rxBitEn) begin
      next_posBit = wrapPos(curBit);
      next_posGroup = curGroup;
      if (curBit == POS_LAST) begin
        next_posGroup = (curGroup == GRP_LAST) ? '0 : curGroup + 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      posBit   <= '0;
      posGroup <= '0;
    end else begin
      posBit   <= next_posBit;
      posGroup <= next_posGroup;
    end
  end

  // ----------------------------------------
  // Serial output
  // ----------------------------------------
  logic serClk;
  logic gapClk;
  logic next_serClk;
  logic next_serData;
  logic next_serFrame;
  logic next_serGap;
  logic next_gapClk;

  always_comb begin
    next_serClk   = serClk;
    next_serData  = rxSerialData;
    next_serFrame = rxFramePulseSerial;
    next_serGap   = rxGapSignal;
    next_gapClk   = gapClk;
    if (rxBitEn) begin
      next_serClk   = 1'b0;
      next_serData  = rxBit;
      next_serFrame = !curFirst;
      next_serGap   = !curOvh;
      next_gapClk   = curOvh;
    end else if (!serClk) begin
      next_serClk = 1'b1;
      next_gapClk = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      serClk             <= 1'b1;
      rxSerialData       <= 1'b0;
      rxFramePulseSerial <= 1'b1;
      rxGapSignal        <= 1'b1;
      gapClk             <= 1'b1;
    end else begin
      serClk             <= next_serClk;
      rxSerialData       <= next_serData;
      rxFramePulseSerial <= next_serFrame;
      rxGapSignal        <= next_serGap;
      gapClk             <= next_gapClk;
    end
  end

  // ----------------------------------------
  // Nibble assembly
  // ----------------------------------------
  logic                nibActive;
  logic [NIB_W-2:0]    shiftNib;
  logic [1:0]          bitCnt;
  ds3rx_nidx_t         nibIdx;
  logic [NIB_W-2:0]    next_shiftNib;
  logic [1:0]          next_bitCnt;
  ds3rx_nidx_t         next_nibIdx;
  logic                pushValid;
  logic                pushReady;
  logic [NIB_W:0]      pushWord;
  logic                next_overrun;

  assign nibActive = cbitParityMode & ~serialSelect;

  always_comb begin
    next_shiftNib = shiftNib;
    next_bitCnt   = rxFrameMark && rxBitEn ? '0 : bitCnt;
    next_nibIdx   = rxFrameMark && rxBitEn ? '0 : nibIdx;
    pushValid     = 1'b0;
    pushWord      = {(next_nibIdx == NIDX_PULSE), shiftNib, rxBit};
    if (rxBitEn && !curOvh && nibActive) begin
      next_shiftNib = {shiftNib[NIB_W-3:0], rxBit};
      if (next_bitCnt == 2'(NIB_W - 1)) begin
        pushValid   = 1'b1;
        next_bitCnt = '0;
        next_nibIdx = (next_nibIdx == NIDX_LAST) ? '0 : next_nibIdx + 1'b1;
      end else begin
        next_bitCnt = next_bitCnt + 1'b1;
      end
    end
    next_overrun = pushValid & ~pushReady;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      shiftNib <= '0;
      bitCnt   <= '0;
      nibIdx   <= '0;
      rxNibbleOverrun <= 1'b0;
    end else begin
      shiftNib <= next_shiftNib;
      bitCnt   <= next_bitCnt;
      nibIdx   <= next_nibIdx;
      rxNibbleOverrun <= next_overrun;
    end
  end

  // ----------------------------------------
  // Nibble buffer
  // ----------------------------------------
  logic           popValid;
  logic           popReady;
  logic [NIB_W:0] popWord;

  ds3rx_fifo #(
    .W     (NIB_W + 1),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .inValid  (pushValid),
    .inReady  (pushReady),
    .inData   (pushWord),
    .outValid (popValid),
    .outReady (popReady),
    .outData  (popWord)
  );

  // ----------------------------------------
  // Nibble output
  // ----------------------------------------
  logic             nibClk;
  logic [NIB_W-1:0] nibData;
  logic             nibFrame;
  logic [1:0]       highCnt;
  logic             next_nibClk;
  logic [NIB_W-1:0] next_nibData;
  logic             next_nibFrame;
  logic [1:0]       next_highCnt;

  assign popReady = ~nibClk;

  always_comb begin
    next_nibClk   = nibClk;
    next_nibData  = nibData;
    next_nibFrame = nibFrame;
    next_highCnt  = highCnt;
    if (popValid && popReady) begin
      next_nibClk   = 1'b1;
      next_nibData  = popWord[NIB_W-1:0];
      next_nibFrame = !popWord[NIB_W];
      next_highCnt  = '0;
    end else if (nibClk && rxBitEn) begin
      if (highCnt == 2'(NIB_HIGH_BITS - 1)) begin
        next_nibClk = 1'b0;
      end else begin
        next_highCnt = highCnt + 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      nibClk   <= 1'b0;
      nibData  <= '0;
      nibFrame <= 1'b1;
      highCnt  <= '0;
    end else begin
      nibClk   <= next_nibClk;
      nibData  <= next_nibData;
      nibFrame <= next_nibFrame;
      highCnt  <= next_highCnt;
    end
  end

  // ----------------------------------------
  // Line transmit regeneration
  // ----------------------------------------
  logic next_txClk;
  logic next_txData;

  always_comb begin
    next_txClk  = txEn;
    next_txData = txEn ? txLineBit : lineTxData;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      lineTxClock <= 1'b0;
      lineTxData  <= 1'b0;
    end else begin
      lineTxClock <= next_txClk;
      lineTxData  <= next_txData;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign rxSerialClock      = serClk;
  assign rxNibbleClock      = nibClk;
  assign rxNibbleBit3       = (serialSelect && gappedClockEnable) ? gapClk : nibData[3];
  assign rxNibbleBit2       = nibData[2];
  assign rxNibbleBit1       = nibData[1];
  assign rxNibbleBit0       = nibData[0];
  assign rxFramePulseNibble = nibFrame;
  assign txBitTake          = txEn;

endmodule

`default_nettype wire

// ==== ds3rx_terminal_port_props.sv ====
// Assertions on the terminal port outputs.
// Bound to ds3rx_terminal_port; sees its ports only.
`timescale 1ns/1ps
`default_nettype none

module ds3rx_terminal_port_props (
  // Clock, reset, modes
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic cbitParityMode,
  input wire logic serialSelect,
  // Transmit path
  input wire logic txLineBit,
  input wire logic txBitTake,
  input wire logic lineTxClock,
  input wire logic lineTxData,
  // Receive outputs
  input wire logic rxSerialClock,
  input wire logic rxSerialData,
  input wire logic rxFramePulseSerial,
  input wire logic rxGapSignal,
  input wire logic rxNibbleClock,
  input wire logic rxNibbleBit2,
  input wire logic rxNibbleBit1,
  input wire logic rxNibbleBit0,
  input wire logic rxFramePulseNibble,
  input wire logic rxNibbleOverrun
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  sequence s_take;
    txBitTake;
  endsequence
  sequence s_txBit;
    lineTxClock && lineTxData == $past(txLineBit) ##1 !lineTxClock;
  endsequence

  a_tx_answer: assert property (s_take |=> s_txBit) else $error("tx bit not sent");
  a_txclk_cause: assert property ($rose(lineTxClock) |-> $past(txBitTake))
    else $error("tx clock without take");
  a_txd_hold: assert property ($changed(lineTxData) |-> lineTxClock)
    else $error("tx data moved off clock");
  a_serclk_pulse: assert property ($fell(rxSerialClock) |=> rxSerialClock)
    else $error("serial clock low too long");
  a_serdata_edge: assert property ($changed(rxSerialData) |-> !rxSerialClock)
    else $error("serial data moved off clock");
  a_gap_edge: assert property ($changed(rxGapSignal) |-> !rxSerialClock)
    else $error("gap moved off clock");
  a_fps_edge: assert property ($changed(rxFramePulseSerial) |-> !rxSerialClock)
    else $error("serial pulse moved off clock");
  a_nib_edge: assert property ($changed({rxNibbleBit2, rxNibbleBit1, rxNibbleBit0})
    |-> $rose(rxNibbleClock)) else $error("nibble moved off clock");
  a_fpn_edge: assert property ($changed(rxFramePulseNibble) |-> $rose(rxNibbleClock))
    else $error("nibble pulse moved off clock");
  a_nibclk_high: assert property ($rose(rxNibbleClock) |-> rxNibbleClock[*3])
    else $error("nibble clock high too short");
  a_nib_refused: assert property ((!cbitParityMode || serialSelect)[*8]
    |-> !$rose(rxNibbleClock)) else $error("nibble clock outside nibble mode");
  a_no_overrun: assert property (!rxNibbleOverrun) else $error("nibble lost");
endmodule

bind ds3rx_terminal_port ds3rx_terminal_port_props u_props (
  .sys_clk, .rst_n, .cbitParityMode, .serialSelect, .txLineBit, .txBitTake,
  .lineTxClock, .lineTxData, .rxSerialClock, .rxSerialData, .rxFramePulseSerial,
  .rxGapSignal, .rxNibbleClock, .rxNibbleBit2, .rxNibbleBit1, .rxNibbleBit0,
  .rxFramePulseNibble, .rxNibbleOverrun
);

`default_nettype wire

// ==== ds3rx_line_sender.sv ====
// Line-side sender model: receive clock, data and frame mark.
// Assumes the bench releases rst_n on a falling edge.
`timescale 1ns/1ps
`default_nettype none

module ds3rx_line_sender
  import ds3rx_pkg::*;
(
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_n,
  // Line receive pins
  output logic      lineRxClock,
  output logic      lineRxData,
  output logic      rxFrameMark
);
  logic [1:0]  phase;
  logic [12:0] bitIdx;
  logic [12:0] nextIdx;

  // ----------------------------------------
  // Bit stream, four system cycles a bit
  // ----------------------------------------
  assign nextIdx = (bitIdx == 13'(FRAME_BITS - 1)) ? 13'h0000 : bitIdx + 13'h0001;
  // Window covers the strobe of frame bit 1 only
  assign rxFrameMark = (bitIdx == 13'h0001);

  // Data set while clock low, taken on the rise
  always @(negedge sys_clk) begin
    if (!rst_n) begin
      phase       <= 2'h0;
      bitIdx      <= 13'h0000;
      lineRxClock <= 1'b0;
      lineRxData  <= 1'b0;
    end else begin
      phase <= phase + 2'h1;
      if (phase == 2'h0) lineRxClock <= 1'b1;
      if (phase == 2'h2) begin
        lineRxClock <= 1'b0;
        bitIdx      <= nextIdx;
        lineRxData  <= nextIdx[1] ^ nextIdx[4];
      end
    end
  end
endmodule

`default_nettype wire

// ==== ds3_rx_terminal_port_tb_top.sv ====
// Self-checking bench for the terminal port.
// Assumes the line sender model drives the receive pins.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin fail_count++; \
  $display("Error %s expected %0h seen %0h", n, e, g); end end

module ds3_rx_terminal_port_tb_top;
  import ds3rx_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic cbitParityMode = 1'b1;
  logic serialSelect = 1'b0;
  logic gappedClockEnable = 1'b0;
  logic transmitClockIn = 1'b0;
  logic txLineBit = 1'b0;
  logic lineRxClock, lineRxData, rxFrameMark, rxSerialClock, rxSerialData;
  logic rxFramePulseSerial, rxGapSignal, rxNibbleClock, rxFramePulseNibble;
  logic rxNibbleBit3, rxNibbleBit2, rxNibbleBit1, rxNibbleBit0;
  logic rxNibbleOverrun, txBitTake, lineTxClock, lineTxData;
  int fail_count = 0;
  int samples_checked = 0;
  int sIdx, nIdx, nPulses, gChecks, ncRises, txCnt, txN, r;
  int gFalls = -1;
  logic sSync = 1'b0, nSync = 1'b0, prevNc = 1'b0, prevGap = 1'b1, prevB3 = 1'b0;
  logic txQ[$];

  always #20 sys_clk = ~sys_clk;

  ds3rx_line_sender PM (.sys_clk, .rst_n, .lineRxClock, .lineRxData, .rxFrameMark);
  ds3rx_terminal_port DUT (
    .sys_clk, .rst_n, .lineRxClock, .lineRxData, .rxFrameMark, .cbitParityMode,
    .serialSelect, .gappedClockEnable, .rxSerialClock, .rxSerialData,
    .rxFramePulseSerial, .rxGapSignal, .rxNibbleClock, .rxNibbleBit3, .rxNibbleBit2,
    .rxNibbleBit1, .rxNibbleBit0, .rxFramePulseNibble, .rxNibbleOverrun,
    .transmitClockIn, .txLineBit, .txBitTake, .lineTxClock, .lineTxData
  );

  function automatic logic expBit(input int i);
    return logic'(i[1] ^ i[4]);
  endfunction

  function automatic logic [3:0] expNib(input int k);
    logic [3:0] v;
    int p;
    for (int j = 0; j < 4; j++) begin
      p = 4 * k + j;
      v[3 - j] = expBit(p / (GROUP_BITS - 1) * GROUP_BITS + 1 + p % (GROUP_BITS - 1));
    end
    return v;
  endfunction

  // ----------------------------------------
  // Stimulus and monitors, falling edge
  // ----------------------------------------
  always @(negedge sys_clk) begin
    txCnt++;
    if (txCnt % 3 == 0) transmitClockIn = ~transmitClockIn;
    if (rst_n && lineTxClock === 1'b1) begin
      txN++;
      `CHK("lineTxData", (txQ.size() > 0) ? txQ.pop_front() : 1'bx, lineTxData)
    end
    txLineBit = txCnt[1] ^ txCnt[3];
    if (txBitTake === 1'b1) txQ.push_back(txLineBit);
    if (rst_n && rxSerialClock === 1'b0) begin
      if (!sSync && rxFramePulseSerial === 1'b0) begin
        sSync = 1'b1;
        sIdx = -1;
      end
      if (sSync) begin
        sIdx = (sIdx + 1) % int'(FRAME_BITS);
        `CHK("rxFramePulseSerial", logic'(sIdx != 0), rxFramePulseSerial)
        `CHK("rxSerialData", expBit(sIdx), rxSerialData)
        `CHK("rxGapSignal", logic'(sIdx % int'(GROUP_BITS) != 0), rxGapSignal)
      end
    end
    if (rst_n && rxNibbleClock === 1'b1 && !prevNc && cbitParityMode && !serialSelect) begin
      if (!nSync && rxFramePulseNibble === 1'b0) begin
        nSync = 1'b1;
        nIdx = PULSE_NIBBLE - 2;
      end
      if (nSync) begin
        nIdx = (nIdx + 1) % int'(NIBBLES);
        if (nIdx == PULSE_NIBBLE - 1) nPulses++;
        `CHK("rxFramePulseNibble", logic'(nIdx != PULSE_NIBBLE - 1), rxFramePulseNibble)
        `CHK("nibble", expNib(nIdx), {rxNibbleBit3, rxNibbleBit2, rxNibbleBit1, rxNibbleBit0})
      end
    end
    if (rxNibbleClock === 1'b1 && !prevNc) ncRises++;
    if (rst_n && serialSelect && gappedClockEnable) begin
      if (prevGap === 1'b1 && rxGapSignal === 1'b0) begin
        if (gFalls >= 0) begin
          `CHK("gapped clock falls", GROUP_BITS - 1, gFalls)
          gChecks++;
        end
        gFalls = 0;
      end
      if (gFalls >= 0 && prevB3 === 1'b1 && rxNibbleBit3 === 1'b0) gFalls++;
    end else gFalls = -1;
    prevNc = rxNibbleClock;
    prevGap = rxGapSignal;
    prevB3 = rxNibbleBit3;
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic waitCount(ref int v, input int goal, input int lim);
    for (int n = 0; n < lim && v < goal; n++) @(negedge sys_clk);
    if (v < goal) begin
      fail_count++;
      $display("Error wait expected %0d seen %0d", goal, v);
      test_done();
    end
  endtask

  // Two nibble frame pulses bracket one whole checked frame
  task automatic t_nibble();
    waitCount(nPulses, 2, 45000);
    `CHK("nibble frames", 1'b1, logic'(nPulses >= 2))
  endtask

  task automatic t_gapped();
    serialSelect = 1'b1;
    gappedClockEnable = 1'b1;
    waitCount(gChecks, 2, 1500);
  endtask

  task automatic t_m13();
    cbitParityMode = 1'b0;
    serialSelect = 1'b0;
    gappedClockEnable = 1'b0;
    repeat (20) @(negedge sys_clk);
    r = ncRises;
    repeat (1000) @(negedge sys_clk);
    `CHK("nibble clocks in M13", r, ncRises)
  endtask

  task automatic t_tx();
    `CHK("tx bits sent", 1'b1, logic'(txN > 100))
    `CHK("tx bits pending", 1'b1, logic'(txQ.size() <= 1))
    `CHK("serial framing found", 1'b1, sSync)
  endtask

  initial begin
    repeat (2) @(negedge sys_clk);
    rst_n = 1'b1;
    t_nibble();
    t_gapped();
    t_m13();
    t_tx();
    test_done();
  end
endmodule

`default_nettype wire
